// ---- dbp_pkg.sv ----
// Package of constants, field layouts and types for the diagnostic bridge pin control
package dbp_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam int CLK_HZ = 200_000_000; // System clock rate
   localparam int CRYSTAL_HZ = 4_000_000; // Reference crystal the pin timing is based on
   localparam int BAUD_FAST = 38400; // Host rate with baud strap high
   localparam int BAUD_SLOW = 9600; // Host rate with baud strap low
   localparam int DIV_FAST = CLK_HZ / BAUD_FAST; // Cycles per bit, rounded down
   localparam int DIV_SLOW = CLK_HZ / BAUD_SLOW; // Cycles per bit, rounded down
   localparam int POR_NS = 1000; // Internal power-on reset hold time in ns
   localparam int POR_CYCLES = (POR_NS * (CLK_HZ / 1_000_000) + 999) / 1000; // Rounded up
   localparam int DATA_BITS = 8; // Host character data bits, no parity
   localparam int STOP_BITS = 1; // Host character stop bits

   ////////////////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [4:0] OFS_CTRL = 5'h00; // Line drive and processing control
   localparam logic [4:0] OFS_STATUS = 5'h04; // Line, RTS and serial status
   localparam logic [4:0] OFS_DATA = 5'h08; // Write: send char, read: received char
   localparam logic [4:0] OFS_CMD = 5'h0c; // Configuration command codes

   // CTRL fields
   localparam int CTRL_SUPPLY = 0;
   localparam int CTRL_POS = 1;
   localparam int CTRL_NEG = 2;
   localparam int CTRL_K = 3;
   localparam int CTRL_L = 4;
   localparam int CTRL_PROC = 5;
   localparam int CTRL_MEM = 6; // Read only, set by strap or command
   localparam int CTRL_LF = 7; // Read only, set by strap or command
   localparam int CTRL_FAST = 8; // Read only, baud strap result

   // STATUS fields; ABORT is write-one-to-clear
   localparam int ST_VPW = 0;
   localparam int ST_K = 1;
   localparam int ST_PWM = 2;
   localparam int ST_RTS = 3;
   localparam int ST_RXV = 4;
   localparam int ST_TXB = 5;
   localparam int ST_OVR = 6;
   localparam int ST_ABORT = 7;
   localparam int ST_INIT = 8;

   // Configuration command codes
   localparam logic [7:0] CMD_MEM_ON = 8'h01; // memory_on_cmd
   localparam logic [7:0] CMD_MEM_OFF = 8'h02; // memory_off_cmd
   localparam logic [7:0] CMD_LF_ON = 8'h03; // linefeed_on_cmd
   localparam logic [7:0] CMD_LF_OFF = 8'h04; // linefeed_off_cmd

   localparam logic [7:0] CHAR_CR = 8'h0d;
   localparam logic [7:0] CHAR_LF = 8'h0a;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} dbp_txph_e;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} dbp_rxph_e;

   typedef struct packed {
      logic busSupplySelect;
      logic posLineDrive;
      logic negLineDrive;
      logic kLineDrive;
      logic lLineDrive;
   } dbp_drive_s;

   typedef struct packed {
      logic hostReceiveIndicator;
      logic hostTransmitIndicator;
      logic vehicleReceiveIndicator;
      logic vehicleTransmitIndicator;
   } dbp_ind_s;

   typedef struct packed {
      logic [7:0] porCnt;
      logic initDone;
      logic memEn;
      logic lfEn;
      logic fastBaud;
      dbp_drive_s drv;
      logic processing;
      logic abortFlag;
      dbp_txph_e txPh;
      logic [15:0] txCnt;
      logic [2:0] txBit;
      logic [7:0] txShift;
      logic [7:0] txHold;
      logic txHoldValid;
      logic pendLf;
      logic txLow;
      dbp_rxph_e rxPh;
      logic [15:0] rxCnt;
      logic [2:0] rxBit;
      logic [7:0] rxShift;
      logic [7:0] rxData;
      logic rxValid;
      logic rxOverrun;
      logic rxPrev;
      logic ack;
      logic [31:0] rdata;
   } dbp_state_s;

endpackage : dbp_pkg

// ---- dbp_pin_control.sv ----
// Pin-level control of the diagnostic bridge: straps, host serial port, bus line pins
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R1: Low master clear holds device in reset.
// R2: Internal power-on reset needs no external pin.
// R3: Memory strap sampled at reset sets default.
// R4: Memory commands override strap any time.
// R5: Baud strap picks 38400 high, 9600 low.
// R6: Line strap high adds LF after CR.
// R7: Linefeed commands change line ending later.
// R8: Supply select high for 8V, low 5V.
// R9: Positive line drive is active high.
// R10: Negative drive active high, PWM only.
// R11: VPW receive active high, low recessive.
// R12: K-line receive active low, high recessive.
// R13: PWM receive active low, high recessive.
// R14: K and L drives active high.
// R15: Low RTS interrupts the running command.
// R16: Host holds RTS low until busy drops.
// R17: Busy high while processing, low when ready.
// R18: Host transmit line idles high.
// R19: Four indicators rest high, low when active.
// R20: Timing derived from one fixed reference.
// R21: Host characters are 8N1 at selected rate.
// R22: Host waits for busy low before commands.
// R23: Straps only sampled at reset.
// R24: Receive idles high, falling edge starts.
module dbp_pin_control
   import dbp_pkg::*;
#(
   parameter int DivFast = DIV_FAST, // Bit period at the fast rate
   parameter int DivSlow = DIV_SLOW // Bit period at the slow rate, 4 to 65535 cycles
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic master_clear_n,
   input wire logic memory_strap,
   input wire logic baud_strap,
   input wire logic line_end_strap,
   input wire logic vpw_receive_in,
   input wire logic k_line_receive_n,
   input wire logic pwm_receive_n,
   input wire logic rts_n,
   input wire logic host_rx_in,
   output logic host_tx_out,
   output logic busy,
   output dbp_drive_s lineDrive,
   output dbp_ind_s indicators_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);

   // Counters are 16 bits wide and the receiver samples at half a bit
   if (DivFast < 4 || DivFast > 65535 || DivSlow < 4 || DivSlow > 65535) begin : g_bad_div
      $error("Bit period parameters out of range");
   end

   localparam logic [15:0] DIV_F = 16'(DivFast); // Sized fast period, see R20
   localparam logic [15:0] DIV_S = 16'(DivSlow); // Sized slow period, see R20
   localparam logic [7:0] POR_LAST = 8'(POR_CYCLES - 1); // Last cycle of power-on hold

   dbp_state_s s_r; // Whole state
   dbp_state_s s_nxt; // Next state
   logic [15:0] bitDiv; // Bit period chosen by the baud strap
   logic vpwDom; // Bus dominant decoded from each receive pin
   logic kDom;
   logic pwmDom;
   logic req; // Bus request pending
   logic wrData; // Write to the transmit data word
   logic txStall; // Holding register full, write must wait
   logic doWrite; // Write takes effect this edge
   logic doRead; // Read completes this edge

   ////////////////////////////////////////////////////////////////////////////////////////
   // Receive pin decoding and bus handshake terms
   always_comb begin
      vpwDom = vpw_receive_in; // see R11
      kDom = ~k_line_receive_n; // see R12
      pwmDom = ~pwm_receive_n; // see R13
      bitDiv = s_r.fastBaud ? DIV_F : DIV_S; // see R5
      req = avs_read | avs_write;
      wrData = avs_write && (avs_address == OFS_DATA);
      txStall = wrData && s_r.txHoldValid;
      doWrite = avs_write && s_r.ack;
      doRead = avs_read && s_r.ack;
      avs_waitrequest = req && !s_r.ack; // Drops one cycle after a request, later for a data write while the holding char is full
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      s_nxt = s_r;
      // Power-on hold, counted from reset release; straps caught on its last cycle
      if (!s_r.initDone) begin
         s_nxt.porCnt = s_r.porCnt + 8'h01; // see R2
         if (s_r.porCnt == POR_LAST) begin
            s_nxt.initDone = 1'b1;
            s_nxt.memEn = memory_strap; // see R3, R23
            s_nxt.fastBaud = baud_strap; // see R5, R23
            s_nxt.lfEn = line_end_strap; // see R6, R23
         end
      end

      // Bus slave: acknowledge one cycle after request, unless a data write finds the holding char full
      s_nxt.ack = req && !s_r.ack && !txStall;
      if (req && !s_r.ack) begin
         case (avs_address)
            OFS_CTRL: begin
               s_nxt.rdata = 32'h0000_0000;
               s_nxt.rdata[CTRL_SUPPLY] = s_r.drv.busSupplySelect;
               s_nxt.rdata[CTRL_POS] = s_r.drv.posLineDrive;
               s_nxt.rdata[CTRL_NEG] = s_r.drv.negLineDrive;
               s_nxt.rdata[CTRL_K] = s_r.drv.kLineDrive;
               s_nxt.rdata[CTRL_L] = s_r.drv.lLineDrive;
               s_nxt.rdata[CTRL_PROC] = s_r.processing;
               s_nxt.rdata[CTRL_MEM] = s_r.memEn;
               s_nxt.rdata[CTRL_LF] = s_r.lfEn;
               s_nxt.rdata[CTRL_FAST] = s_r.fastBaud;
            end
            OFS_STATUS: begin
               s_nxt.rdata = 32'h0000_0000;
               s_nxt.rdata[ST_VPW] = vpwDom;
               s_nxt.rdata[ST_K] = kDom;
               s_nxt.rdata[ST_PWM] = pwmDom;
               s_nxt.rdata[ST_RTS] = ~rts_n;
               s_nxt.rdata[ST_RXV] = s_r.rxValid;
               s_nxt.rdata[ST_TXB] = (s_r.txPh != TX_IDLE) | s_r.txHoldValid | s_r.pendLf;
               s_nxt.rdata[ST_OVR] = s_r.rxOverrun;
               s_nxt.rdata[ST_ABORT] = s_r.abortFlag;
               s_nxt.rdata[ST_INIT] = s_r.initDone;
            end
            OFS_DATA: s_nxt.rdata = {24'h00_0000, s_r.rxData};
            default: s_nxt.rdata = 32'h0000_0000; // Command word and unmapped read zero
         endcase
      end

      // Register writes, taken only at the edge where waitrequest is low
      if (doWrite) begin
         case (avs_address)
            OFS_CTRL: begin
               // Field by field: the struct runs MSB first, the register LSB first
               s_nxt.drv.busSupplySelect = avs_writedata[CTRL_SUPPLY]; // see R8
               s_nxt.drv.posLineDrive = avs_writedata[CTRL_POS]; // see R9
               s_nxt.drv.negLineDrive = avs_writedata[CTRL_NEG]; // see R10
               s_nxt.drv.kLineDrive = avs_writedata[CTRL_K]; // see R14
               s_nxt.drv.lLineDrive = avs_writedata[CTRL_L]; // see R14
               s_nxt.processing = avs_writedata[CTRL_PROC];
            end
            OFS_STATUS: begin
               if (avs_writedata[ST_ABORT]) begin
                  s_nxt.abortFlag = 1'b0;
               end
               if (avs_writedata[ST_OVR]) begin
                  s_nxt.rxOverrun = 1'b0;
               end
            end
            OFS_DATA: begin
               s_nxt.txHold = avs_writedata[7:0];
               s_nxt.txHoldValid = 1'b1;
            end
            OFS_CMD: begin
               case (avs_writedata[7:0])
                  CMD_MEM_ON: s_nxt.memEn = 1'b1; // see R4
                  CMD_MEM_OFF: s_nxt.memEn = 1'b0; // see R4
                  CMD_LF_ON: s_nxt.lfEn = 1'b1; // see R7
                  CMD_LF_OFF: s_nxt.lfEn = 1'b0; // see R7
                  default: ; // Unknown codes are ignored
               endcase
            end
            default: ; // Unmapped writes are ignored
         endcase
      end
      if (doRead && avs_address == OFS_DATA) begin
         s_nxt.rxValid = 1'b0; // A new character below still sets it
      end

      // Host attention request cuts short whatever is being processed
      if (!rts_n && s_r.processing) begin
         s_nxt.processing = 1'b0; // see R15
         s_nxt.abortFlag = 1'b1; // Set wins over a clear in the same cycle
      end else if (!rts_n) begin
         s_nxt.processing = 1'b0; // see R15
      end

      // Transmitter, 8N1, line idle high; a CR may be followed by an automatic LF
      case (s_r.txPh)
         TX_IDLE: begin
            s_nxt.txLow = 1'b0; // see R18
            if (s_r.initDone && s_r.pendLf) begin
               s_nxt.pendLf = 1'b0;
               s_nxt.txShift = CHAR_LF; // see R6
               s_nxt.txPh = TX_START;
               s_nxt.txCnt = bitDiv - 16'h0001;
               s_nxt.txLow = 1'b1;
            end else if (s_r.initDone && s_r.txHoldValid) begin
               s_nxt.txHoldValid = 1'b0;
               s_nxt.txShift = s_r.txHold;
               s_nxt.pendLf = (s_r.txHold == CHAR_CR) && s_r.lfEn; // see R6, R7
               s_nxt.txPh = TX_START;
               s_nxt.txCnt = bitDiv - 16'h0001;
               s_nxt.txLow = 1'b1;
            end
         end
         TX_START, TX_DATA, TX_STOP: begin
            s_nxt.txCnt = s_r.txCnt - 16'h0001;
            if (s_r.txCnt == 16'h0000) begin
               s_nxt.txCnt = bitDiv - 16'h0001;
               if (s_r.txPh == TX_START) begin
                  s_nxt.txPh = TX_DATA; // see R21
                  s_nxt.txBit = 3'h0;
                  s_nxt.txLow = ~s_r.txShift[0];
               end else if (s_r.txPh == TX_DATA && s_r.txBit != 3'(DATA_BITS - 1)) begin
                  s_nxt.txBit = s_r.txBit + 3'h1;
                  s_nxt.txShift = {1'b0, s_r.txShift[7:1]};
                  s_nxt.txLow = ~s_r.txShift[1];
               end else if (s_r.txPh == TX_DATA) begin
                  s_nxt.txPh = TX_STOP; // see R21
                  s_nxt.txLow = 1'b0;
               end else begin
                  s_nxt.txPh = TX_IDLE;
               end
            end
         end
         default: s_nxt.txPh = TX_IDLE;
      endcase

      // Receiver: falling edge starts, samples at mid-bit, a bad start bit is dropped
      s_nxt.rxPrev = host_rx_in;
      case (s_r.rxPh)
         RX_IDLE: begin
            if (s_r.initDone && s_r.rxPrev && !host_rx_in) begin
               s_nxt.rxPh = RX_START; // see R24
               s_nxt.rxCnt = {1'b0, bitDiv[15:1]};
            end
         end
         RX_START, RX_DATA, RX_STOP: begin
            s_nxt.rxCnt = s_r.rxCnt - 16'h0001;
            if (s_r.rxCnt == 16'h0000) begin
               s_nxt.rxCnt = bitDiv - 16'h0001;
               if (s_r.rxPh == RX_START) begin
                  s_nxt.rxPh = host_rx_in ? RX_IDLE : RX_DATA; // Glitch rejected
                  s_nxt.rxBit = 3'h0;
               end else if (s_r.rxPh == RX_DATA) begin
                  s_nxt.rxShift = {host_rx_in, s_r.rxShift[7:1]};
                  s_nxt.rxBit = s_r.rxBit + 3'h1;
                  if (s_r.rxBit == 3'(DATA_BITS - 1)) begin
                     s_nxt.rxPh = RX_STOP; // see R21
                  end
               end else begin
                  s_nxt.rxPh = RX_IDLE;
                  if (host_rx_in) begin
                     s_nxt.rxData = s_r.rxShift; // Framing errors are dropped
                     // An unread char is lost; a same-cycle read or clear is honoured first
                     s_nxt.rxOverrun = s_nxt.rxOverrun | s_nxt.rxValid;
                     s_nxt.rxValid = 1'b1;
                  end
               end
            end
         end
         default: s_nxt.rxPh = RX_IDLE;
      endcase

      // Master clear restarts from the initial state, power-on hold included
      if (!master_clear_n) begin
         s_nxt = '0; // see R1
         s_nxt.rxPrev = host_rx_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // State register; all-zero is the initial state, so reset loads only constants
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Outputs
   always_comb begin
      host_tx_out = ~s_r.txLow; // see R18
      busy = s_r.processing | ~s_r.initDone; // see R17
      avs_readdata = s_r.rdata;
      lineDrive = s_r.drv; // see R8, R9, R14
      // The negative line is only driven while the 5V PWM supply is selected
      lineDrive.negLineDrive = s_r.drv.negLineDrive & ~s_r.drv.busSupplySelect; // see R10
      indicators_n.hostReceiveIndicator = (s_r.rxPh == RX_IDLE); // see R19
      indicators_n.hostTransmitIndicator = (s_r.txPh == TX_IDLE); // see R19
      indicators_n.vehicleReceiveIndicator = ~(vpwDom | kDom | pwmDom); // see R19
      indicators_n.vehicleTransmitIndicator = ~(|lineDrive[3:0]); // see R19, lines as driven
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence seq_cr_sent;
      (s_r.txPh == TX_IDLE && s_r.initDone && !s_r.pendLf && s_r.txHoldValid
         && s_r.txHold == CHAR_CR && s_r.lfEn && master_clear_n);
   endsequence
   sequence seq_lf_start;
      (s_r.txPh == TX_START && s_r.txShift == CHAR_LF);
   endsequence

   a_rts_abort: assert property (!rts_n && master_clear_n |=> !busy || !s_r.initDone) // see R15
      else $error("Busy stayed high with RTS low");
   a_tx_idle_high: assert property (s_r.txPh == TX_IDLE |-> host_tx_out) // see R18
      else $error("Transmit line low while idle");
   a_baud_strap: assert property ($rose(s_r.initDone) // see R5
      |-> s_r.fastBaud == $past(baud_strap))
      else $error("Baud rate does not follow strap");
   a_lf_after_cr: assert property (seq_cr_sent |=> s_r.pendLf) // see R6
      else $error("No linefeed queued after CR");
   a_lf_order: assert property (s_r.pendLf && s_r.txPh == TX_STOP // see R6
      && s_r.txCnt == 16'h0000 |=> ##1 seq_lf_start)
      else $error("Linefeed did not follow");
   a_neg_pwm_only: assert property (doWrite && avs_address == OFS_CTRL // see R10
      && master_clear_n && avs_writedata[CTRL_SUPPLY]
      |=> lineDrive.busSupplySelect && !lineDrive.negLineDrive)
      else $error("Negative drive outside PWM supply");
   a_k_polarity: assert property (k_line_receive_n && pwm_receive_n && !vpw_receive_in // see R12
      |-> indicators_n.vehicleReceiveIndicator)
      else $error("Recessive bus shown as active");
   a_clear_restart: assert property (!master_clear_n // see R1
      |=> !s_r.initDone && s_r.txPh == TX_IDLE)
      else $error("Master clear did not restart");
   a_mem_cmd: assert property (doWrite && avs_address == OFS_CMD // see R4
      && avs_writedata[7:0] == CMD_MEM_OFF && master_clear_n |=> !s_r.memEn)
      else $error("Memory off command ignored");
   a_wait_one: assert property (req && !txStall && !s_r.ack && master_clear_n
      |=> !avs_waitrequest || !req)
      else $error("Waitrequest held too long");
   a_busy_level: assert property (doWrite && avs_address == OFS_CTRL && rts_n // see R17
      && master_clear_n && avs_writedata[CTRL_PROC] |=> busy)
      else $error("Busy low while processing");
   a_rx_start: assert property (s_r.rxPh == RX_IDLE && s_r.initDone && master_clear_n // see R24
      && s_r.rxPrev && !host_rx_in |=> s_r.rxPh == RX_START)
      else $error("Start edge not taken");

endmodule : dbp_pin_control

// ---- dbp_host_model.sv ----
// Host serial port model: sends and collects 8N1 characters
`timescale 1ns/10ps
module dbp_host_model
   import dbp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic host_tx_out,
   input wire integer bitDiv,
   output logic host_rx_in
);
   logic [7:0] rxQ[$]; // Characters collected from the device
   int badFrames = 0; // Frames whose stop bit was low

   // Line idles high between characters
   initial host_rx_in = 1'b1;

   // Send one character, start bit, LSB first, one stop bit
   task automatic send_byte(input logic [7:0] ch);
      logic [9:0] frame;
      frame = {1'b1, ch, 1'b0};
      for (int i = 0; i < 10; i++) begin
         host_rx_in <= frame[i];
         repeat (bitDiv) @(posedge sys_clk);
      end
   endtask : send_byte

   // Collector samples mid-bit; waiting for high first keeps reset glitches out
   initial begin : collect
      logic [7:0] ch;
      forever begin
         wait (host_tx_out === 1'b1);
         @(negedge host_tx_out);
         repeat (bitDiv / 2) @(posedge sys_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (bitDiv) @(posedge sys_clk);
            ch[i] = host_tx_out;
         end
         repeat (bitDiv) @(posedge sys_clk);
         if (host_tx_out !== 1'b1) badFrames++;
         rxQ.push_back(ch);
      end
   end
endmodule : dbp_host_model

// ---- dbp_pin_control_tb.sv ----
// Self-checking testbench of the diagnostic bridge pin control
`timescale 1ns/10ps
module dbp_pin_control_tb
   import dbp_pkg::*;
;
   // Short bit periods keep the serial traffic quick
   localparam int TB_DIV_FAST = 8;
   localparam int TB_DIV_SLOW = 16;
   localparam logic [7:0] CMD_TAB [4] = '{CMD_MEM_OFF, CMD_MEM_ON, CMD_LF_OFF, CMD_LF_ON};
   localparam logic [31:0] CTRL_TAB [4] = '{32'h180, 32'h1c0, 32'h140, 32'h1c0};

   logic sys_clk, reset, master_clear_n, memory_strap, baud_strap, line_end_strap;
   logic vpw_receive_in, k_line_receive_n, pwm_receive_n, rts_n, host_rx_in, host_tx_out;
   logic busy, avs_read, avs_write, avs_waitrequest;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   dbp_drive_s lineDrive;
   dbp_ind_s indicators_n;
   int bitDiv; // Bit period the host model uses
   int errors = 0;
   int tests_run = 0;

   dbp_pin_control #(.DivFast(TB_DIV_FAST), .DivSlow(TB_DIV_SLOW)) u_dbp_pin_control (
      .sys_clk(sys_clk), .reset(reset), .master_clear_n(master_clear_n),
      .memory_strap(memory_strap), .baud_strap(baud_strap),
      .line_end_strap(line_end_strap), .vpw_receive_in(vpw_receive_in),
      .k_line_receive_n(k_line_receive_n), .pwm_receive_n(pwm_receive_n), .rts_n(rts_n),
      .host_rx_in(host_rx_in), .host_tx_out(host_tx_out), .busy(busy),
      .lineDrive(lineDrive), .indicators_n(indicators_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

   dbp_host_model u_dbp_host_model (.sys_clk(sys_clk), .host_tx_out(host_tx_out),
      .bitDiv(bitDiv), .host_rx_in(host_rx_in));

   // 200 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Verdict, comparison and bus tasks
   task automatic report_and_stop;
      if (errors == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   task automatic timeout(input string msg);
      errors++;
      $display("mismatch at %0t: no answer for %s", $time, msg);
      report_and_stop();
   endtask : timeout

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask : chk

   // Holds the request until waitrequest is sampled low; the edge first avoids re-raising
   task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                           output logic [31:0] rdat);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      rdat = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 100) timeout("bus request");
   endtask : bus_xfer

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] unused;
      bus_xfer(1'b1, a, d, unused);
   endtask : wr

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] mask, input logic [31:0] exp,
                         input string msg);
      logic [31:0] got;
      bus_xfer(1'b0, a, 32'h0, got);
      chk(got & mask, exp, msg);
   endtask : rd_chk

   // Poll one status bit until set, bounded
   task automatic wait_bit(input int b);
      logic [31:0] st;
      int n;
      n = 0;
      do begin
         bus_xfer(1'b0, OFS_STATUS, 32'h0, st);
         n++;
      end while (st[b] !== 1'b1 && n < 300);
      if (n >= 300) timeout("status bit");
   endtask : wait_bit

   ////////////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin : main
      int n;
      {reset, master_clear_n, memory_strap, baud_strap, line_end_strap} = 5'h1f;
      {vpw_receive_in, k_line_receive_n, pwm_receive_n, rts_n} = 4'h7;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      bitDiv = TB_DIV_FAST;
      repeat (6) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk(32'(busy), 32'h1, "busy in power-on hold");
      chk(32'({host_tx_out, indicators_n}), 32'h1f, "idle tx and indicators");
      wait_bit(ST_INIT);
      chk(32'(busy), 32'h0, "busy after hold");
      rd_chk(5'h10, 32'hffffffff, 32'h0, "unmapped read");
      rd_chk(OFS_CTRL, 32'h1c0, 32'h1c0, "straps high");
      {memory_strap, baud_strap, line_end_strap} <= 3'h0;
      rd_chk(OFS_CTRL, 32'h1c0, 32'h1c0, "late strap change");
      for (int i = 0; i < 4; i++) begin
         wr(OFS_CMD, {24'h0, CMD_TAB[i]});
         rd_chk(OFS_CTRL, 32'h1c0, CTRL_TAB[i], "config command");
      end
      // Negative drive is gated while the 8V supply is selected
      wr(OFS_CTRL, 32'h1f);
      repeat (2) @(posedge sys_clk);
      chk(32'(lineDrive), 32'h1b, "drives with 8V");
      chk(32'(indicators_n.vehicleTransmitIndicator), 32'h0, "vehicle tx lamp");
      wr(OFS_CTRL, 32'h1e);
      repeat (2) @(posedge sys_clk);
      chk(32'(lineDrive), 32'h0f, "drives with 5V");
      wr(OFS_CTRL, 32'h0);
      // Receive pins dominant, then recessive
      {vpw_receive_in, k_line_receive_n, pwm_receive_n} <= 3'b100;
      rd_chk(OFS_STATUS, 32'h7, 32'h7, "receive dominant");
      chk(32'(indicators_n.vehicleReceiveIndicator), 32'h0, "vehicle rx lamp");
      {vpw_receive_in, k_line_receive_n, pwm_receive_n} <= 3'b011;
      rd_chk(OFS_STATUS, 32'h7, 32'h0, "receive recessive");
      // Processing aborted by the host; host holds request until busy drops
      wr(OFS_CTRL, 32'h20);
      repeat (2) @(posedge sys_clk);
      chk(32'(busy), 32'h1, "busy while processing");
      rts_n <= 1'b0;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (busy !== 1'b0 && n < 10);
      if (n >= 10) timeout("busy drop");
      rts_n <= 1'b1;
      rd_chk(OFS_STATUS, 32'h88, 32'h80, "abort flag");
      wr(OFS_STATUS, 32'h80);
      rd_chk(OFS_STATUS, 32'h80, 32'h0, "abort cleared");
      // CR with linefeed on is followed by LF
      wr(OFS_DATA, {24'h0, CHAR_CR});
      repeat (20) @(posedge sys_clk);
      chk(32'(indicators_n.hostTransmitIndicator), 32'h0, "host tx lamp");
      repeat (400) @(posedge sys_clk);
      chk(u_dbp_host_model.rxQ.size(), 2, "char count lf on");
      chk(32'(u_dbp_host_model.rxQ[0]), 32'h0d, "first char");
      chk(32'(u_dbp_host_model.rxQ[1]), 32'h0a, "second char");
      // Character from the host
      fork
         u_dbp_host_model.send_byte(8'h5a);
         begin
            repeat (20) @(posedge sys_clk);
            chk(32'(indicators_n.hostReceiveIndicator), 32'h0, "host rx lamp");
         end
      join
      wait_bit(ST_RXV);
      rd_chk(OFS_DATA, 32'hff, 32'h5a, "received char");
      rd_chk(OFS_STATUS, 32'h10, 32'h0, "rx valid cleared");
      // Master clear with straps low: slow rate, CR only, memory off
      master_clear_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      master_clear_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk(32'(busy), 32'h1, "busy after clear");
      wait_bit(ST_INIT);
      rd_chk(OFS_CTRL, 32'h1ff, 32'h0, "straps low after clear");
      bitDiv = TB_DIV_SLOW;
      u_dbp_host_model.rxQ.delete();
      wr(OFS_DATA, {24'h0, CHAR_CR});
      repeat (600) @(posedge sys_clk);
      chk(u_dbp_host_model.rxQ.size(), 1, "char count lf off");
      chk(32'(u_dbp_host_model.rxQ[0]), 32'h0d, "slow rate char");
      chk(u_dbp_host_model.badFrames, 0, "stop bits");
      report_and_stop();
   end
endmodule : dbp_pin_control_tb
